// *** src/sadc_defs.vh ***
// shared constants for the sampling converter readout control
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// local clock period
`define SADC_CLK_PERIOD_NS 40

// conversion time, timed from the local clock
`define SADC_T_CONVERT_STROBE_N_NS 18000

// convert strobe low to first internal serial clock rising edge
`define SADC_T_FIRST_CLK_NS 2000

// internal serial clock high and low time
`define SADC_T_SBCLK_HALF_NS 410

// lag from serial clock fall to data change, inside the low phase
`define SADC_T_DATA_LAG_NS 200

// result word layout
`define SADC_WORD_BITS 16
`define SADC_WORD_MSB 15
`define SADC_RESULT_RST 16'h0000

// result buffer depth and its pointer width
`define SADC_FIFO_DEPTH 16
`define SADC_FIFO_AW 4

// synchronised pin vector positions
`define SADC_PIN_SBCLK 0
`define SADC_PIN_CONVERT_STROBE_N 1
`define SADC_PIN_CS 2
`define SADC_PIN_SEL 3
`define SADC_PIN_POWER_DOWN_REQUEST 4
`define SADC_PIN_CNT 5

// synchroniser reset levels, one bit per pin position
`define SADC_PIN_RST 5'h0e

`endif

// *** src/sadc_fifo.v ***
// result buffer with valid and ready on both sides
`timescale 1ns/10ps
module sadc_fifo #(
	parameter W  = 16,
	parameter D  = 16,
	parameter AW = 4
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// filling side
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	// draining side
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:D-1];
	reg [AW:0]  wr_q;
	reg [AW:0]  rd_q;
	wire        full;
	wire        empty;
	wire        push;
	wire        pop;

	// honest full and empty from pointers with a wrap bit
	assign empty       = (wr_q == rd_q);
	assign full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign push        = in_valid_i & ~full;
	assign pop         = out_ready_i & ~empty;
	assign out_data_o  = mem[rd_q[AW-1:0]];

	// storage write, no reset needed on data
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// pointer update
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// *** src/sadc_top.v ***
// conversion sequencing and serial result readout of the sampling converter
`timescale 1ns/10ps
`include "sadc_defs.vh"

// Operation
// - internal source: drive serial clock pin out
// - external source: pin is input, host clocks
// - chip select high floats driven serial clock
// - serial output carries last completed result
// - internal clock: data stable across both edges
// - chip select high floats serial data
// - conversion always timed by internal clock
// - convert strobe fall holds and starts conversion
// - strobe falls during conversion are ignored
// - internal source: previous result shifts during conversion
// - chip select low enables data and busy; serial clock only with internal source
// - busy low from start to conversion end
// - internal source: transmission only while busy low
// - chip select high floats busy
// - power down request enters low power
// - strobe level at power-up release harmless
// - sixteen bit twos complement, msb first
// - external source: load shifter before busy rises
module sadc_top (
	// clock and reset
	input  wire        MCLK_I,
	input  wire        RST_I,
	// host control pins
	input  wire        CONVERT_STROBE_N_I,
	input  wire        CHIP_SELECT_N_I,
	input  wire        CLOCK_SOURCE_SELECT_I,
	input  wire        POWER_DOWN_REQUEST_I,
	// converter core result, same clock domain
	input  wire [15:0] RESULT_I,
	// serial bit clock pin, two-way
	input  wire        SERIAL_BIT_CLOCK_I,
	output wire        SERIAL_BIT_CLOCK_O,
	output wire        SERIAL_BIT_CLOCK_OE_N_O,
	// serial data pin
	output wire        SERIAL_DATA_O,
	output wire        SERIAL_DATA_OE_N_O,
	// busy pin, low while converting
	output wire        BUSY_O,
	output wire        BUSY_OE_N_O,
	// status
	output wire        SAMPLE_HOLD_O,
	output wire        LOW_POWER_O
);
	////////////////////////////////////////////////////////////////////////////////
	// timing counts derived from the local clock

	localparam [31:0] CONVERT_STROBE_N_CYC  = (`SADC_T_CONVERT_STROBE_N_NS + `SADC_CLK_PERIOD_NS - 1)
		/ `SADC_CLK_PERIOD_NS;
	localparam [31:0] FIRST_CYC = (`SADC_T_FIRST_CLK_NS + `SADC_CLK_PERIOD_NS - 1)
		/ `SADC_CLK_PERIOD_NS;
	localparam [31:0] HALF_CYC  = `SADC_T_SBCLK_HALF_NS / `SADC_CLK_PERIOD_NS;
	localparam [31:0] LAG_CYC   = (`SADC_T_DATA_LAG_NS + `SADC_CLK_PERIOD_NS - 1)
		/ `SADC_CLK_PERIOD_NS;
	localparam [31:0] PER_CYC   = 2 * HALF_CYC;
	localparam [31:0] WORD_MSB  = `SADC_WORD_MSB;

	// counter widths and sized compare values, cut from the wide counts
	localparam [9:0] CONVERT_STROBE_N_LAST  = CONVERT_STROBE_N_CYC[9:0] - 10'h001;
	localparam [6:0] FIRST_LAST = FIRST_CYC[6:0] - 7'h01;
	localparam [4:0] HALF_PH    = HALF_CYC[4:0];
	localparam [4:0] LAG_PH     = LAG_CYC[4:0];
	localparam [4:0] PER_LAST   = PER_CYC[4:0] - 5'h01;
	localparam [4:0] BIT_LAST   = WORD_MSB[4:0];

	// sequencer states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CONVERT_STROBE_N = 2'h1;
	localparam [1:0] ST_PUSH = 2'h2;
	localparam [1:0] ST_LOAD = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	wire [`SADC_PIN_CNT-1:0] pin_raw;
	reg  [`SADC_PIN_CNT-1:0] pin_m_q;
	reg  [`SADC_PIN_CNT-1:0] pin_s_q;
	reg                      sbclk_d1_q;
	reg                      convert_strobe_n_d1_q;

	// reset levels follow each pin's idle level: clock low, strobe high,
	// select high, no power down; release then makes no false edge or pulse
	localparam [`SADC_PIN_CNT-1:0] PIN_RST = `SADC_PIN_RST;

	assign pin_raw[`SADC_PIN_SBCLK] = SERIAL_BIT_CLOCK_I;
	assign pin_raw[`SADC_PIN_CONVERT_STROBE_N]  = CONVERT_STROBE_N_I;
	assign pin_raw[`SADC_PIN_CS]    = CHIP_SELECT_N_I;
	assign pin_raw[`SADC_PIN_SEL]   = CLOCK_SOURCE_SELECT_I;
	assign pin_raw[`SADC_PIN_POWER_DOWN_REQUEST]  = POWER_DOWN_REQUEST_I;

	// two flops per pin; the first is read by the second only
	genvar gi;
	generate
		for (gi = 0; gi < `SADC_PIN_CNT; gi = gi + 1) begin : g_sync
			always @(posedge MCLK_I or posedge RST_I) begin
				if (RST_I) begin
					pin_m_q[gi] <= PIN_RST[gi];
					pin_s_q[gi] <= PIN_RST[gi];
				end else begin
					pin_m_q[gi] <= pin_raw[gi];
					pin_s_q[gi] <= pin_m_q[gi];
				end
			end
		end
	endgenerate

	wire sbclk_s = pin_s_q[`SADC_PIN_SBCLK];
	wire convert_strobe_n_n_s = pin_s_q[`SADC_PIN_CONVERT_STROBE_N];
	wire cs_n_s   = pin_s_q[`SADC_PIN_CS];
	wire ext_s    = pin_s_q[`SADC_PIN_SEL];
	wire power_down_request_s   = pin_s_q[`SADC_PIN_POWER_DOWN_REQUEST];

	// edge history taken from the synchronised copies
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			sbclk_d1_q <= 1'b0; // idle level of the clock pin
			convert_strobe_n_d1_q  <= 1'b1;
		end else begin
			sbclk_d1_q <= sbclk_s;
			convert_strobe_n_d1_q  <= convert_strobe_n_n_s;
		end
	end

	// a strobe fall is only an edge, never a held low level
	wire convert_strobe_n_fall  = convert_strobe_n_d1_q & ~convert_strobe_n_n_s;
	wire sbclk_rise = ~sbclk_d1_q & sbclk_s;

	////////////////////////////////////////////////////////////////////////////////
	// result buffer between the converter core and the shifter

	reg         push_q;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [15:0] fifo_out_data;
	reg         fifo_pop;

	sadc_fifo #(
		.W  (`SADC_WORD_BITS),
		.D  (`SADC_FIFO_DEPTH),
		.AW (`SADC_FIFO_AW)
	) u_fifo (
		.clk_i       (MCLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (push_q),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (RESULT_I),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	reg  [1:0] st_q;
	reg  [1:0] st_d;
	reg  [9:0] convert_strobe_n_cnt_q;
	reg        busy_q;
	reg        hold_q;
	reg        lowp_q;
	wire       start;
	wire       convert_strobe_n_done;

	// starts need a real fall, no power down, and an idle sequencer
	assign start     = convert_strobe_n_fall & ~power_down_request_s & (st_q == ST_IDLE);
	assign convert_strobe_n_done = (st_q == ST_CONVERT_STROBE_N) && (convert_strobe_n_cnt_q == CONVERT_STROBE_N_LAST);

	// next state; a full buffer holds the sequencer in the push state
	// the load state drains the buffer so the newest word ends in the shifter
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d = ST_CONVERT_STROBE_N;
				end
			end
			ST_CONVERT_STROBE_N: begin
				if (convert_strobe_n_done) begin
					st_d = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (fifo_in_ready) begin
					st_d = ext_s ? ST_LOAD : ST_IDLE;
				end
			end
			ST_LOAD: begin
				if (!fifo_out_valid) begin
					st_d = ST_IDLE; // newest word loaded last
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// state, conversion timer, push strobe, busy and hold
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q       <= ST_IDLE;
			convert_strobe_n_cnt_q <= 10'h000;
			push_q     <= 1'b0;
			busy_q     <= 1'b1;
			hold_q     <= 1'b0;
			lowp_q     <= 1'b0;
		end else begin
			st_q       <= st_d;
			convert_strobe_n_cnt_q <= (st_q == ST_CONVERT_STROBE_N) ? convert_strobe_n_cnt_q + 10'h001 : 10'h000;
			push_q     <= (st_d == ST_PUSH) & ~(push_q & fifo_in_ready);
			busy_q     <= (st_d == ST_IDLE);
			hold_q     <= (st_d == ST_CONVERT_STROBE_N);
			lowp_q     <= power_down_request_s & (st_q == ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// internal serial clock generator, runs only inside a conversion

	reg  [6:0] lead_cnt_q;
	reg  [4:0] ph_q;
	reg  [4:0] bit_q;
	reg        ser_on_q;
	reg        sbclk_q;
	wire       int_run = ~ext_s & (st_q == ST_CONVERT_STROBE_N);
	wire       ph_end  = (ph_q == PER_LAST);
	wire       lag_hit = ser_on_q & (ph_q == LAG_PH) & (bit_q != 5'h00);

	// lead time, then sixteen periods of low half and high half
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			lead_cnt_q <= 7'h00;
			ph_q       <= 5'h00;
			bit_q      <= 5'h00;
			ser_on_q   <= 1'b0;
			sbclk_q    <= 1'b0;
		end else if (!int_run) begin
			lead_cnt_q <= 7'h00;
			ph_q       <= 5'h00;
			bit_q      <= 5'h00;
			ser_on_q   <= 1'b0;
			sbclk_q    <= 1'b0;
		end else if (!ser_on_q) begin
			if (lead_cnt_q == FIRST_LAST) begin
				ser_on_q <= (bit_q == 5'h00);
			end else begin
				lead_cnt_q <= lead_cnt_q + 7'h01;
			end
		end else begin
			ph_q    <= ph_end ? 5'h00 : ph_q + 5'h01;
			sbclk_q <= (ph_q == HALF_PH - 5'h01) ? 1'b1 : (ph_end ? 1'b0 : sbclk_q);
			if (ph_end) begin
				if (bit_q == BIT_LAST) begin
					ser_on_q <= 1'b0; // last fall, clock parks low while busy
					bit_q    <= 5'h10;
				end else begin
					bit_q <= bit_q + 5'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output shifter

	reg  [15:0] sh_q;
	reg  [15:0] last_q;
	reg         data_q;
	wire        int_load = start & ~ext_s;
	wire        ext_load = (st_q == ST_LOAD) & fifo_out_valid;

	// pop the head word when a load is made
	// a word left over from internal mode is drained before the newest one
	always @* begin
		fifo_pop = int_load | ext_load;
		if (int_load & ~fifo_out_valid) begin
			fifo_pop = 1'b0;
		end
	end

	// load, then shift msb first; a start without a new word replays the last one
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			sh_q   <= `SADC_RESULT_RST;
			last_q <= `SADC_RESULT_RST;
		end else if (int_load) begin
			sh_q   <= fifo_out_valid ? fifo_out_data : last_q;
			last_q <= fifo_out_valid ? fifo_out_data : last_q;
		end else if (ext_load) begin
			sh_q   <= fifo_out_data;
			last_q <= fifo_out_data;
		end else if (ext_s & sbclk_rise) begin
			sh_q <= {sh_q[14:0], 1'b0};
		end else if (~ext_s & lag_hit) begin
			sh_q <= {sh_q[14:0], 1'b0}; // change mid low phase only
		end
	end

	// data pin register follows the shifter msb
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			data_q <= 1'b0;
		end else begin
			data_q <= sh_q[`SADC_WORD_MSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output enables from chip select and clock source

	reg data_oe_n_q;
	reg busy_oe_n_q;
	reg sbclk_oe_n_q;

	// chip select gates drivers only, never conversions
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			data_oe_n_q  <= 1'b1;
			busy_oe_n_q  <= 1'b1;
			sbclk_oe_n_q <= 1'b1;
		end else begin
			data_oe_n_q  <= cs_n_s;
			busy_oe_n_q  <= cs_n_s;
			sbclk_oe_n_q <= cs_n_s | ext_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output drive

	assign SERIAL_BIT_CLOCK_O      = sbclk_q;
	assign SERIAL_BIT_CLOCK_OE_N_O = sbclk_oe_n_q;
	assign SERIAL_DATA_O           = data_q;
	assign SERIAL_DATA_OE_N_O      = data_oe_n_q;
	assign BUSY_O                  = busy_q;
	assign BUSY_OE_N_O             = busy_oe_n_q;
	assign SAMPLE_HOLD_O           = hold_q;
	assign LOW_POWER_O             = lowp_q;
endmodule

// *** verification/sadc_host.sv ***
// host controller model: convert strobe and external serial clock
`timescale 1ns/10ps
module sadc_host (
	// clock
	input  wire logic clk_i,
	// data pin from the converter
	input  wire logic sdata_i,
	// pins to the converter
	output logic      convert_strobe_n_n_o,
	output logic      sclk_o
);
	////////////////////////////////////////
	// idle levels: strobe high, clock still and low
	initial begin
		convert_strobe_n_n_o = 1'b1;
		sclk_o = 1'b0;
	end
	// strobe pulse, then spacing before the next start
	task automatic strobe(input int lo, input int gap);
		convert_strobe_n_n_o <= 1'b0;
		repeat (lo) @(posedge clk_i);
		convert_strobe_n_n_o <= 1'b1;
		repeat (gap) @(posedge clk_i);
	endtask
	// sixteen 320 ns clocks, bit taken just before each rise
	task automatic read_ext(output logic [15:0] w);
		w = 16'h0000;
		repeat (16) begin
			w = {w[14:0], sdata_i};
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule

// *** verification/sadc_top_assertions.sv ***
// concurrent checks on the readout control pins
`timescale 1ns/10ps
module sadc_top_assertions (
	// clock, reset and host pins
	input logic MCLK_I,
	input logic RST_I,
	input logic CONVERT_STROBE_N_I,
	input logic CHIP_SELECT_N_I,
	input logic CLOCK_SOURCE_SELECT_I,
	input logic POWER_DOWN_REQUEST_I,
	// converter outputs
	input logic SERIAL_BIT_CLOCK_O,
	input logic SERIAL_BIT_CLOCK_OE_N_O,
	input logic SERIAL_DATA_O,
	input logic SERIAL_DATA_OE_N_O,
	input logic BUSY_O,
	input logic BUSY_OE_N_O,
	input logic SAMPLE_HOLD_O,
	input logic LOW_POWER_O
);
	logic [9:0] busy_cnt_q;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	////////////////////////////////////////
	// cycles spent with busy low so far
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			busy_cnt_q <= 10'h000;
		else if (BUSY_O)
			busy_cnt_q <= 10'h000;
		else
			busy_cnt_q <= busy_cnt_q + 10'h001;
	end
	AST_START: assert property (
		(!POWER_DOWN_REQUEST_I) [*4] ##0 ($fell(CONVERT_STROBE_N_I) && BUSY_O && !LOW_POWER_O)
		|-> ##[2:6] (!BUSY_O && SAMPLE_HOLD_O)) else $error("no start after strobe");
	AST_BUSY_LEN: assert property (
		$rose(BUSY_O) |-> (busy_cnt_q >= 10'h1c2) && (busy_cnt_q <= 10'h1f4))
		else $error("busy low time wrong");
	AST_CLK_IN_BUSY: assert property (
		$rose(SERIAL_BIT_CLOCK_O) |-> !BUSY_O) else $error("serial clock outside busy");
	AST_DATA_STABLE: assert property (
		$rose(SERIAL_BIT_CLOCK_O) |-> $stable(SERIAL_DATA_O) [*8] ##1 $stable(SERIAL_DATA_O) [*4])
		else $error("data moved near clock edge");
	AST_EXT_CLK: assert property (
		CLOCK_SOURCE_SELECT_I [*6] |-> SERIAL_BIT_CLOCK_OE_N_O) else $error("clock pin driven");
	AST_CLK_DRIVEN: assert property (
		(!CHIP_SELECT_N_I && !CLOCK_SOURCE_SELECT_I) [*6] |-> !SERIAL_BIT_CLOCK_OE_N_O)
		else $error("clock pin not driven");
	AST_CS_ENABLES: assert property (
		(!CHIP_SELECT_N_I) [*6] |-> !SERIAL_DATA_OE_N_O && !BUSY_OE_N_O)
		else $error("outputs not enabled");
	AST_CS_FLOATS: assert property (
		CHIP_SELECT_N_I [*6] |-> SERIAL_DATA_OE_N_O && BUSY_OE_N_O && SERIAL_BIT_CLOCK_OE_N_O)
		else $error("outputs not floated");
	AST_LOW_POWER: assert property (
		(POWER_DOWN_REQUEST_I && BUSY_O) [*6] |-> LOW_POWER_O) else $error("no low power");
	AST_AWAKE: assert property (
		(!POWER_DOWN_REQUEST_I) [*6] |-> !LOW_POWER_O) else $error("low power stuck");
endmodule
bind sadc_top sadc_top_assertions chk (.MCLK_I, .RST_I, .CONVERT_STROBE_N_I, .CHIP_SELECT_N_I,
	.CLOCK_SOURCE_SELECT_I, .POWER_DOWN_REQUEST_I, .SERIAL_BIT_CLOCK_O, .SERIAL_BIT_CLOCK_OE_N_O,
	.SERIAL_DATA_O, .SERIAL_DATA_OE_N_O, .BUSY_O, .BUSY_OE_N_O, .SAMPLE_HOLD_O, .LOW_POWER_O);

// *** verification/sadc_top_tb.sv ***
// self-checking bench for the readout control
`timescale 1ns/10ps
module sadc_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cs_n = 1'b0;
	logic        sel = 1'b1;
	logic        pd = 1'b0;
	logic [15:0] res = 16'h0000;
	logic [15:0] cap = 16'h0000;
	logic        sck_q = 1'b0;
	logic        busy_q = 1'b1;
	int          nbits = 0;
	int          falls = 0;
	int          seed = 32'hbc03;
	int          mismatches = 0;
	int          n_compared = 0;
	wire         convert_strobe_n_n, hclk, sck, sck_oe_n, sdat, sdat_oe_n, busy, busy_oe_n, hold, lowp;
	wire         clk_pin = sck_oe_n ? hclk : sck;
	wire         dat_pin = sdat_oe_n ? ~sdat : sdat;
	////////////////////////////////////////
	always #20 clk = ~clk;
	sadc_host host (.clk_i(clk), .sdata_i(dat_pin), .convert_strobe_n_n_o(convert_strobe_n_n), .sclk_o(hclk));
	sadc_top uut (.MCLK_I(clk), .RST_I(rst), .CONVERT_STROBE_N_I(convert_strobe_n_n),
		.CHIP_SELECT_N_I(cs_n), .CLOCK_SOURCE_SELECT_I(sel), .POWER_DOWN_REQUEST_I(pd),
		.RESULT_I(res), .SERIAL_BIT_CLOCK_I(clk_pin), .SERIAL_BIT_CLOCK_O(sck),
		.SERIAL_BIT_CLOCK_OE_N_O(sck_oe_n), .SERIAL_DATA_O(sdat), .SERIAL_DATA_OE_N_O(sdat_oe_n),
		.BUSY_O(busy), .BUSY_OE_N_O(busy_oe_n), .SAMPLE_HOLD_O(hold), .LOW_POWER_O(lowp));
	// gather internally clocked bits and count conversion starts
	always @(posedge clk) begin
		sck_q <= sck;
		busy_q <= busy;
		if (sck && !sck_q) begin
			cap <= {cap[14:0], sdat};
			nbits <= nbits + 1;
		end
		if (!busy && busy_q)
			falls <= falls + 1;
	end
	task automatic check_bit(input string nm, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// the word a read should return: previous result on the internal clock
	function automatic logic [15:0] exp_word(input logic internal, input logic [15:0] now_w,
		input logic [15:0] prev_w);
		return internal ? prev_w : now_w;
	endfunction
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one conversion; split adds a strobe while busy is low
	task automatic convert(input logic [15:0] r, input logic split);
		int f0;
		f0 = falls;
		res <= r;
		if (split) begin
			host.strobe(3, 100);
			host.strobe(3, 516);
		end else
			host.strobe(3, 622);
		check_word("starts", 16'(f0 + 1), 16'(falls));
		check_bit("busy idle", 1'b1, busy & ~hold);
	endtask
	initial begin
		logic [15:0] r, w, prev;
		int n0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// host clock: each result read after its own conversion
		for (int i = 0; i < 3; i++) begin
			r = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($random(seed));
			convert(r, 1'b0);
			check_bit("clk oe_n", 1'b1, sck_oe_n);
			host.read_ext(w);
			check_word("ext word", exp_word(1'b0, r, prev), w);
			prev = r;
		end
		$display("test external clock done");
		sel <= 1'b0;
		repeat (8) @(posedge clk);
		// internal clock: previous result sent during the conversion
		for (int i = 0; i < 4; i++) begin
			r = 16'($random(seed));
			cs_n <= (i == 2);
			n0 = nbits;
			convert(r, i == 3);
			if (i == 2)
				check_bit("float", 1'b1, sck_oe_n & sdat_oe_n & busy_oe_n);
			else begin
				check_bit("clk oe_n", 1'b0, sck_oe_n | sdat_oe_n | busy_oe_n);
				check_word("bits", 16'h0010, 16'(nbits - n0));
				check_word("int word", exp_word(1'b1, r, prev), cap);
			end
			prev = r;
		end
		$display("test internal clock done");
		// power down, strobe refused, strobe held low across release
		pd <= 1'b1;
		repeat (10) @(posedge clk);
		check_bit("low power", 1'b1, lowp);
		n0 = falls;
		fork
			host.strobe(40, 10);
			begin
				repeat (20) @(posedge clk);
				pd <= 1'b0;
			end
		join
		check_word("no start", 16'(n0), 16'(falls));
		check_bit("awake", 1'b0, lowp);
		n0 = nbits;
		convert(16'($random(seed)), 1'b0);
		check_word("bits", 16'h0010, 16'(nbits - n0));
		check_word("int word", exp_word(1'b1, r, prev), cap);
		$display("test power down done");
		// back to the host clock with the last internal word still buffered
		sel <= 1'b1;
		repeat (8) @(posedge clk);
		r = 16'($random(seed));
		convert(r, 1'b0);
		host.read_ext(w);
		check_word("ext word", exp_word(1'b0, r, prev), w);
		$display("test source switch done");
		conclude();
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule
